// File: core/hbcc_top.sv
// four-channel half-bridge control with fixed off-time chopping
//
// What this block does
// - each output drives high side when its phase is high, low side when low
// - low-power request low puts every output in high impedance
// - phase low keeps low side on until current reaches chop threshold
// - at threshold, low side off and high side on for selected off-time
// - off-time over: low side on again, cycle repeats while phase low
// - new off-time selection applies only after 10 us stable
// - comparator ignored about 1 us after each low-side enable; minimum on-time
// - outputs 1 and 2 use reference a, outputs 3 and 4 reference b
// - chopping keeps regulating with phase held low continuously
// - fault flag pulled low on any fault, released when supply fault gone and thermal and overcurrent latches cleared
// - off-time codes give 7, 16, 24 and 32 us
// - overcurrent lasting 1.8 us disables that bridge and latches a fault
// - low pulse between 20 and 40 us clears latched faults
`timescale 1ns/1ns
module hbcc_top (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic lowPowerRequest,
  input wire logic [hbcc_pkg::CH_NUM-1:0] phaseInput,
  input wire logic [1:0] offTimeSelect,
  input wire logic [1:0] chopThresholdRefA,
  input wire logic [1:0] chopThresholdRefB,
  input wire logic [hbcc_pkg::CH_NUM-1:0] overcurrentTrip,
  input wire logic supplyFault,
  input wire logic thermalFault,
  output logic [hbcc_pkg::CH_NUM-1:0] highSideOn,
  output logic [hbcc_pkg::CH_NUM-1:0] lowSideOn,
  output logic faultFlagLowOut,
  output logic faultFlagLowOe
);
  import hbcc_pkg::*;

  // ----------------------------------------------------------------
  // input synchronisation
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] rawIn;
  logic [SYNC_W-1:0] syncIn;
  logic [CH_NUM-1:0] phaseS;
  logic lowPowerS;
  logic [1:0] tselS;
  logic [CH_NUM-1:0] cmpS;
  logic [CH_NUM-1:0] ocS;
  logic supplyS;
  logic thermS;

  assign rawIn = {phaseInput, lowPowerRequest, offTimeSelect, chopThresholdRefB,
                  chopThresholdRefA, overcurrentTrip, supplyFault, thermalFault};

  hbcc_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .asyncIn(rawIn),
    .syncOut(syncIn)
  );

  // channels 0..1 see reference a, 2..3 see reference b
  assign {phaseS, lowPowerS, tselS, cmpS, ocS, supplyS, thermS} = syncIn;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  hbcc_top_state_t state_reg;
  hbcc_top_state_t state_next;
  logic clearPulse;
  logic chanEnable;
  logic [CNT_W-1:0] offCyc;

  always_comb begin
    state_next = state_reg;
    clearPulse = 1'b0;
    chanEnable = 1'b0;
    offCyc = hbcc_off_cycles(state_reg.tselApplied);

    // --------------------------------------------------------------
    // off-time select deglitch
    // --------------------------------------------------------------
    if (tselS != state_reg.tselCand) begin
      state_next.tselCand = tselS;
      state_next.stableCnt = '0;
    end else if (state_reg.tselCand != state_reg.tselApplied) begin
      if (state_reg.stableCnt == DEGLITCH_CYC - 1'b1) begin
        state_next.tselApplied = state_reg.tselCand;
        state_next.stableCnt = '0;
      end else begin
        state_next.stableCnt = state_reg.stableCnt + 1'b1;
      end
    end

    // --------------------------------------------------------------
    // low-power request: low-time measure and fault clear
    // --------------------------------------------------------------
    if (!lowPowerS) begin
      if (state_reg.lowCnt != PULSE_MAX_CYC) begin
        state_next.lowCnt = state_reg.lowCnt + 1'b1;
      end
    end else begin
      state_next.lowCnt = '0;
    end
    // longer low (sleep) also clears, as logic restarts on wake
    clearPulse = lowPowerS && !state_reg.lpPrev
                 && (state_reg.lowCnt > PULSE_MIN_CYC);
    state_next.lpPrev = lowPowerS;

    // thermal fault latches; a new event wins over a clear
    if (thermS) begin
      state_next.thermLatch = 1'b1;
    end else if (clearPulse) begin
      state_next.thermLatch = 1'b0;
    end

    chanEnable = lowPowerS && !supplyS && !thermS && !state_reg.thermLatch;

    // --------------------------------------------------------------
    // per-channel bridge and chopper
    // --------------------------------------------------------------
    for (int i = 0; i < CH_NUM; i++) begin
      // overcurrent deglitch and latch
      if (ocS[i]) begin
        if (state_reg.ch[i].ocpCnt != OCP_CYC) begin
          state_next.ch[i].ocpCnt = state_reg.ch[i].ocpCnt + 1'b1;
        end
      end else begin
        state_next.ch[i].ocpCnt = '0;
      end
      // set holds against a clear while the overcurrent persists
      if (ocS[i] && state_reg.ch[i].ocpCnt >= OCP_CYC - 1'b1) begin
        state_next.ch[i].ocpLatch = 1'b1;
      end else if (clearPulse) begin
        state_next.ch[i].ocpLatch = 1'b0;
      end

      case (state_reg.ch[i].st)
        CH_OFF: begin
          if (chanEnable) begin
            state_next.ch[i].cnt = '0;
            if (phaseS[i]) begin
              state_next.ch[i].st = CH_HIGH;
            end else begin
              state_next.ch[i].st = CH_CHARGE;
            end
          end
        end
        CH_HIGH: begin
          if (!phaseS[i]) begin
            state_next.ch[i].st = CH_CHARGE;
            state_next.ch[i].cnt = '0;
          end
        end
        CH_CHARGE: begin
          if (phaseS[i]) begin
            state_next.ch[i].st = CH_HIGH;
          end else if (state_reg.ch[i].cnt != BLANK_CYC - 1'b1) begin
            state_next.ch[i].cnt = state_reg.ch[i].cnt + 1'b1;
          end else if (cmpS[i]) begin
            state_next.ch[i].st = CH_DECAY;
            state_next.ch[i].cnt = '0;
          end
        end
        CH_DECAY: begin
          if (phaseS[i]) begin
            state_next.ch[i].st = CH_HIGH;
          end else if (state_reg.ch[i].cnt >= offCyc - 1'b1) begin
            state_next.ch[i].st = CH_CHARGE;
            state_next.ch[i].cnt = '0;
          end else begin
            state_next.ch[i].cnt = state_reg.ch[i].cnt + 1'b1;
          end
        end
        CH_TRIP: begin
          if (!state_next.ch[i].ocpLatch) begin
            state_next.ch[i].st = CH_OFF;
          end
        end
        default: begin
          state_next.ch[i].st = CH_OFF;
          state_next.ch[i].cnt = '0;
        end
      endcase

      // faults and sleep override the chopper
      if (state_next.ch[i].ocpLatch) begin
        state_next.ch[i].st = CH_TRIP;
        state_next.ch[i].cnt = '0;
      end else if (!chanEnable) begin
        state_next.ch[i].st = CH_OFF;
        state_next.ch[i].cnt = '0;
      end

      state_next.ch[i].hs = (state_next.ch[i].st == CH_HIGH)
                            || (state_next.ch[i].st == CH_DECAY);
      state_next.ch[i].ls = (state_next.ch[i].st == CH_CHARGE);
    end

    // --------------------------------------------------------------
    // fault flag
    // --------------------------------------------------------------
    state_next.faultOe = supplyS || state_next.thermLatch;
    for (int i = 0; i < CH_NUM; i++) begin
      if (state_next.ch[i].ocpLatch) begin
        state_next.faultOe = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_reg <= '0;
      state_reg.tselCand <= TSEL_RESET;
      state_reg.tselApplied <= TSEL_RESET;
      for (int i = 0; i < CH_NUM; i++) begin
        state_reg.ch[i].st <= CH_OFF;
      end
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < CH_NUM; i++) begin
      highSideOn[i] = state_reg.ch[i].hs;
      lowSideOn[i] = state_reg.ch[i].ls;
    end
  end

  // open drain: only ever pulls low
  assign faultFlagLowOut = 1'b0;
  assign faultFlagLowOe = state_reg.faultOe;

endmodule // hbcc_top

// File: shared/hbcc_pkg.sv
// constants and types shared by the half-bridge chopper control
package hbcc_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int CH_NUM = 4;
  localparam int CNT_W = 10;
  localparam int OCP_W = 6;
  localparam int STAB_W = 8;
  localparam int SYNC_W = 17;

  // ----------------------------------------------------------------
  // timing, in ns as printed, and derived cycle counts
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int BLANK_TIME_NS = 1000;
  localparam int OCP_TIME_NS = 1800;
  localparam int DEGLITCH_TIME_NS = 10000;
  localparam int PULSE_MIN_TIME_NS = 20000;
  localparam int PULSE_MAX_TIME_NS = 40000;
  localparam int OFF_LOW_TIME_NS = 7000;
  localparam int OFF_HIGH_TIME_NS = 16000;
  localparam int OFF_HIZ_TIME_NS = 24000;
  localparam int OFF_RES_TIME_NS = 32000;

  localparam logic [CNT_W-1:0] BLANK_CYC =
    CNT_W'((BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [OCP_W-1:0] OCP_CYC =
    OCP_W'((OCP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [STAB_W-1:0] DEGLITCH_CYC =
    STAB_W'((DEGLITCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] PULSE_MIN_CYC = CNT_W'(PULSE_MIN_TIME_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] PULSE_MAX_CYC = CNT_W'(PULSE_MAX_TIME_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] OFF_LOW_CYC = CNT_W'(OFF_LOW_TIME_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] OFF_HIGH_CYC = CNT_W'(OFF_HIGH_TIME_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] OFF_HIZ_CYC = CNT_W'(OFF_HIZ_TIME_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] OFF_RES_CYC = CNT_W'(OFF_RES_TIME_NS / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // off-time select codes from the quad-level front end
  // ----------------------------------------------------------------
  localparam logic [1:0] TSEL_TIED_LOW = 2'h0;
  localparam logic [1:0] TSEL_TIED_HIGH = 2'h1;
  localparam logic [1:0] TSEL_HIZ = 2'h2;
  localparam logic [1:0] TSEL_RES_GND = 2'h3;
  localparam logic [1:0] TSEL_RESET = TSEL_TIED_LOW;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    CH_OFF = 5'h01,
    CH_HIGH = 5'h02,
    CH_CHARGE = 5'h04,
    CH_DECAY = 5'h08,
    CH_TRIP = 5'h10
  } hbcc_ch_state_t;

  typedef struct packed {
    hbcc_ch_state_t st;
    logic [CNT_W-1:0] cnt;
    logic [OCP_W-1:0] ocpCnt;
    logic ocpLatch;
    logic hs;
    logic ls;
  } hbcc_ch_t;

  typedef struct packed {
    hbcc_ch_t [CH_NUM-1:0] ch;
    logic [1:0] tselCand;
    logic [1:0] tselApplied;
    logic [STAB_W-1:0] stableCnt;
    logic [CNT_W-1:0] lowCnt;
    logic lpPrev;
    logic thermLatch;
    logic faultOe;
  } hbcc_top_state_t;

  // ----------------------------------------------------------------
  // off-time in cycles for a select code
  // ----------------------------------------------------------------
  function automatic logic [CNT_W-1:0] hbcc_off_cycles(input logic [1:0] code);
    logic [CNT_W-1:0] cyc;
    cyc = OFF_LOW_CYC;
    case (code)
      TSEL_TIED_LOW: cyc = OFF_LOW_CYC;
      TSEL_TIED_HIGH: cyc = OFF_HIGH_CYC;
      TSEL_HIZ: cyc = OFF_HIZ_CYC;
      TSEL_RES_GND: cyc = OFF_RES_CYC;
      default: cyc = OFF_LOW_CYC;
    endcase
    return cyc;
  endfunction

endpackage

// File: core/hbcc_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module hbcc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } hbcc_sync_state_t;

  hbcc_sync_state_t state_reg;
  hbcc_sync_state_t state_next;

  always_comb begin
    state_next = state_reg;
    state_next.stage1 = asyncIn;
    state_next.stage2 = state_reg.stage1;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign syncOut = state_reg.stage2;

endmodule // hbcc_sync

// File: dv/hbcc_asserts.sv
// port checker for the half-bridge chopper control
`timescale 1ns/1ns
module hbcc_asserts (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic lowPowerRequest,
  input wire logic [hbcc_pkg::CH_NUM-1:0] phaseInput,
  input wire logic [hbcc_pkg::CH_NUM-1:0] overcurrentTrip,
  input wire logic supplyFault,
  input wire logic [hbcc_pkg::CH_NUM-1:0] highSideOn,
  input wire logic [hbcc_pkg::CH_NUM-1:0] lowSideOn,
  input wire logic faultFlagLowOut,
  input wire logic faultFlagLowOe
);
  import hbcc_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic [CH_NUM-1:0][5:0] ocpRun;
  // run length of each overcurrent pin, saturating
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < CH_NUM; i++) begin
      if (sys_rst || !overcurrentTrip[i]) begin
        ocpRun[i] <= 6'h00;
      end else if (ocpRun[i] != 6'h3F) begin
        ocpRun[i] <= ocpRun[i] + 6'h01;
      end
    end
  end
  never_both_a: assert property (!(|(highSideOn & lowSideOn))) else $error("both on");
  sleep_hiz_a: assert property ((!lowPowerRequest)[*4] |-> !(|{highSideOn, lowSideOn}))
    else $error("not hi-z");
  flag_od_a: assert property (faultFlagLowOut == 1'b0) else $error("flag data high");
  supply_off_a: assert property (supplyFault[*4] |-> faultFlagLowOe && !(|highSideOn))
    else $error("supply fault ignored");
  for (genvar i = 0; i < CH_NUM; i++) begin : g_ch
    sequence toHs;
      $fell(lowSideOn[i]) && $rose(highSideOn[i]);
    endsequence
    sequence toLs;
      $rose(lowSideOn[i]) && $fell(highSideOn[i]);
    endsequence
    phase_high_a: assert property (
      (lowPowerRequest && phaseInput[i] && !supplyFault && !faultFlagLowOe)[*8]
      |-> highSideOn[i]) else $error("high side off");
    blank_min_a: assert property (toHs ##0 !$past(phaseInput[i], 3)
      |-> $past(lowSideOn[i], 20)) else $error("on-time short");
    decay_len_a: assert property (toLs ##0 !$past(phaseInput[i], 4)
      |-> $past(highSideOn[i], 140)) else $error("off-time short");
    ocp_trip_a: assert property (ocpRun[i] >= 6'h2A
      |-> faultFlagLowOe && !highSideOn[i] && !lowSideOn[i]) else $error("no trip");
  end
endmodule // hbcc_asserts

bind hbcc_top hbcc_asserts u_hbcc_asserts (.clk_sys, .sys_rst, .lowPowerRequest, .phaseInput,
  .overcurrentTrip, .supplyFault, .highSideOn, .lowSideOn, .faultFlagLowOut, .faultFlagLowOe);

// File: dv/hbcc_ctrl_model.sv
// controller model driving the phase and low-power request pins
`timescale 1ns/1ns
module hbcc_ctrl_model (
  input wire logic clk_sys,
  output logic lowPowerRequest,
  output logic [hbcc_pkg::CH_NUM-1:0] phaseInput
);
  import hbcc_pkg::*;
  initial begin
    lowPowerRequest = 1'b0;
    phaseInput = '0;
  end
  task automatic set_phase(input logic [CH_NUM-1:0] v);
    @(negedge clk_sys);
    phaseInput = v;
  endtask
  task automatic set_awake(input logic v);
    @(negedge clk_sys);
    lowPowerRequest = v;
  endtask
  // low pulse of n cycles; 401 or more clears faults
  task automatic sleep_pulse(input int n);
    set_awake(1'b0);
    repeat (n) @(negedge clk_sys);
    lowPowerRequest = 1'b1;
  endtask
  // duty kept short enough that current cannot run away
  task automatic pwm(input int ch, input int lo, input int hi, input int n);
    repeat (n) begin
      set_phase(phaseInput & ~(CH_NUM'(1) << ch));
      repeat (lo) @(negedge clk_sys);
      phaseInput = phaseInput | (CH_NUM'(1) << ch);
      repeat (hi) @(negedge clk_sys);
    end
  endtask
endmodule // hbcc_ctrl_model

// File: dv/tb_top.sv
// self-checking bench for the half-bridge chopper control
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module tb_top;
  import hbcc_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic lowPowerRequest;
  logic supplyFault;
  logic thermalFault;
  logic faultFlagLowOut, faultFlagLowOe;
  logic [1:0] offTimeSelect, chopThresholdRefA, chopThresholdRefB;
  logic [CH_NUM-1:0] phaseInput, highSideOn, lowSideOn;
  logic [CH_NUM-1:0] overcurrentTrip;
  int err_total = 0, tests_run = 0, cycles = 0, hs, ls;
  int offUs [4] = '{7, 16, 24, 32};
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end
  hbcc_top u_hbcc_top (.clk_sys, .sys_rst, .lowPowerRequest, .phaseInput, .offTimeSelect,
    .chopThresholdRefA, .chopThresholdRefB, .overcurrentTrip, .supplyFault, .thermalFault,
    .highSideOn, .lowSideOn, .faultFlagLowOut, .faultFlagLowOe);
  hbcc_ctrl_model u_hbcc_ctrl_model (.clk_sys, .lowPowerRequest, .phaseInput);
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      err_total++;
      end_of_test();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // lengths of the next whole high-side and low-side runs
  task automatic runs(input int ch);
    int k;
    for (k = 0; !lowSideOn[ch] && k < 2000; k++) cyc(1);
    for (k = 0; !highSideOn[ch] && k < 2000; k++) cyc(1);
    for (hs = 0; highSideOn[ch] && hs < 2000; hs++) cyc(1);
    for (ls = 0; lowSideOn[ch] && ls < 2000; ls++) cyc(1);
  endtask
  task automatic t_bridge;
    u_hbcc_ctrl_model.set_awake(1'b1);
    for (int v = 0; v < 16; v++) begin
      u_hbcc_ctrl_model.set_phase(4'(v));
      cyc(4);
      `CHK(highSideOn, 4'(v))
      `CHK(lowSideOn, ~4'(v))
    end
    u_hbcc_ctrl_model.pwm(3, 30, 160, 2);
    `CHK(highSideOn[3], 1'b1)
    u_hbcc_ctrl_model.set_awake(1'b0);
    cyc(4);
    `CHK({highSideOn, lowSideOn}, 8'h00)
    $display("bridge test done");
  endtask
  task automatic t_chop;
    u_hbcc_ctrl_model.set_awake(1'b1);
    u_hbcc_ctrl_model.set_phase(4'h0);
    chopThresholdRefB = 2'h1;
    cyc(100);
    `CHK(lowSideOn[1:0], 2'h3)
    for (int r = 0; r < 2; r++) begin
      runs(2);
      `CHK(hs, 140)
      `CHK(ls, 20)
    end
    chopThresholdRefB = 2'h0;
    chopThresholdRefA = 2'h2;
    runs(1);
    `CHK(hs, 140)
    `CHK(lowSideOn[3], 1'b1)
    chopThresholdRefA = 2'h0;
    $display("chop test done");
  endtask
  task automatic t_off_time_select;
    chopThresholdRefA = 2'h1;
    for (int c = 1; c < 5; c++) begin
      offTimeSelect = 2'(c);
      cyc(230);
      runs(0);
      `CHK(hs, offUs[c % 4] * 20)
    end
    offTimeSelect = 2'h3;
    cyc(150);
    offTimeSelect = 2'h0;
    cyc(230);
    runs(0);
    `CHK(hs, 140)
    chopThresholdRefA = 2'h0;
    $display("off-time test done");
  endtask
  task automatic t_fault;
    u_hbcc_ctrl_model.set_phase(4'hF);
    overcurrentTrip = 4'h2;
    cyc(30);
    `CHK({faultFlagLowOe, highSideOn}, 5'h0F)
    cyc(15);
    overcurrentTrip = 4'h0;
    cyc(10);
    `CHK({faultFlagLowOe, highSideOn}, 5'h1D)
    u_hbcc_ctrl_model.sleep_pulse(200);
    cyc(10);
    `CHK(faultFlagLowOe, 1'b1)
    // overcurrent still present across a clear pulse keeps the latch
    overcurrentTrip = 4'h2;
    u_hbcc_ctrl_model.sleep_pulse(600);
    cyc(10);
    `CHK({faultFlagLowOe, highSideOn}, 5'h1D)
    overcurrentTrip = 4'h0;
    u_hbcc_ctrl_model.sleep_pulse(600);
    cyc(10);
    `CHK({faultFlagLowOe, highSideOn}, 5'h0F)
    thermalFault = 1'b1;
    cyc(3);
    thermalFault = 1'b0;
    cyc(10);
    `CHK({faultFlagLowOe, highSideOn}, 5'h10)
    `CHK(faultFlagLowOut, 1'b0)
    u_hbcc_ctrl_model.sleep_pulse(600);
    supplyFault = 1'b1;
    cyc(5);
    `CHK({faultFlagLowOe, highSideOn}, 5'h10)
    supplyFault = 1'b0;
    cyc(8);
    `CHK({faultFlagLowOe, highSideOn}, 5'h0F)
    $display("fault test done");
  endtask
  initial begin
    supplyFault = 1'b0;
    thermalFault = 1'b0;
    offTimeSelect = 2'h0;
    chopThresholdRefA = 2'h0;
    chopThresholdRefB = 2'h0;
    overcurrentTrip = 4'h0;
    cyc(3);
    `CHK({highSideOn, lowSideOn, faultFlagLowOe}, 9'h000)
    cyc(1);
    sys_rst = 1'b0;
    t_bridge();
    t_chop();
    t_off_time_select();
    t_fault();
    end_of_test();
  end
endmodule // tb_top
